// *** core/rsh_regs.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef RSH_REGS_SVH
`define RSH_REGS_SVH

// Register byte offsets on the Wishbone side
`define RSH_OFS_CTRL 8'h00
`define RSH_OFS_TXDATA 8'h04
`define RSH_OFS_RXDATA 8'h08
`define RSH_OFS_STATUS 8'h0c

// Control register fields
`define RSH_CTRL_CODE_LSB 0
`define RSH_CTRL_OP_LSB 6
`define RSH_CTRL_LEN_LSB 8
`define RSH_CTRL_KEEP 16
`define RSH_CTRL_LONG 17

// Status register bits
`define RSH_ST_BUSY 0
`define RSH_ST_TXFULL 1
`define RSH_ST_RXVALID 2
`define RSH_ST_IRQ 3
`define RSH_ST_ERR 4
`define RSH_ST_HOLD 5

// Reset values
`define RSH_RST_BYTE 8'h00
`define RSH_RST_WORD 32'h0000_0000

// Operation selectors and special codes
`define RSH_OP_REG_WR 2'b00
`define RSH_OP_REG_RD 2'b01
`define RSH_OP_FIFO 2'b10
`define RSH_OP_DCMD 2'b11
`define RSH_CODE_FIFO_LOAD 6'h00
`define RSH_CODE_FIFO_READ 6'h3f
`define RSH_FIFO_MAX 96

// Timing: figures in ns, counts in 10 ns cycles
`define RSH_CLK_NS 10
`define RSH_SCLK_MIN_NS 167
`define RSH_NCSL_NS 25
`define RSH_NCSH_NS 300
`define RSH_SSH_NS 100
`define RSH_SCLK_HALF \
  ((`RSH_SCLK_MIN_NS + 2 * `RSH_CLK_NS - 1) / (2 * `RSH_CLK_NS))
`define RSH_NCSL_CYC ((`RSH_NCSL_NS + `RSH_CLK_NS - 1) / `RSH_CLK_NS)
`define RSH_NCSH_CYC ((`RSH_NCSH_NS + `RSH_CLK_NS - 1) / `RSH_CLK_NS)
`define RSH_SSH_CYC ((`RSH_SSH_NS + `RSH_CLK_NS - 1) / `RSH_CLK_NS)

`endif

// *** core/rsh_pkg.sv ***
// Types shared by the serial host controller
package rsh_pkg;

  // Wishbone request from the bus master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } rsh_wb_req_t;

  // Wishbone answer to the bus master
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } rsh_wb_rsp_t;

  // One queued serial operation
  typedef struct packed {
    logic [1:0] op;
    logic [5:0] code;
    logic [6:0] len;
    logic keep;
    logic long;
  } rsh_cmd_t;

  // Sequencer states, Gray along the usual path up to RSH_SSHI; the return to RSH_IDLE flips all three bits
  typedef enum logic [2:0] {
    RSH_IDLE = 3'b000,
    RSH_LEAD = 3'b001,
    RSH_SHIFT = 3'b011,
    RSH_GAP = 3'b010,
    RSH_TAIL = 3'b110,
    RSH_SSHI = 3'b111,
    RSH_WAITIRQ = 3'b101,
    RSH_HOLD = 3'b100
  } rsh_state_t;

endpackage

// *** core/rsh_sync.sv ***
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module rsh_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Asynchronous in, synchronous out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule // rsh_sync

// *** core/rsh_sclk_div.sv ***
// Serial clock divider with edge strobes
`timescale 1ns/1ns
module rsh_sclk_div #(
  parameter int HALF = 9
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Control
  input wire logic run_i,
  // Serial clock and strobes one cycle before each edge
  output logic sclk_o,
  output logic rise_o,
  output logic fall_o
);
  localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);
  logic [CW-1:0] cnt;
  logic wrap;

  assign wrap = run_i && (cnt == LAST);
  assign rise_o = wrap && !sclk_o;
  assign fall_o = wrap && sclk_o;

  // Half-period counter; clock rests low when stopped
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt <= '0;
      sclk_o <= 1'b0;
    end else if (!run_i) begin
      cnt <= '0;
      sclk_o <= 1'b0;
    end else if (wrap) begin
      cnt <= '0;
      sclk_o <= ~sclk_o;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end
endmodule // rsh_sclk_div

// *** core/rsh_host.sv ***
// Serial host controller for the reader port, Wishbone register side
`timescale 1ns/1ns
`include "rsh_regs.svh"
// Functional notes
// - Bytes of eight; first two bits pick operation.
// - Every byte travels most significant bit first.
// - 00 write, 01 read, six address bits.
// - Device drives on rise, master samples falling.
// - FIFO load: 10, zero code, 1..96 bytes.
// - FIFO read: 10, code all ones.
// - Direct command: one byte, operation 11.
// - No traffic during long command until interrupt.
// - Immediate command may chain without raising select.
// - Master keeps select high while idle.
module rsh_host
  import rsh_pkg::*;
#(
  parameter int HALF = `RSH_SCLK_HALF,
  parameter int FIFO_MAX = `RSH_FIFO_MAX
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Wishbone slave
  input wire rsh_wb_req_t wb_req_i,
  output rsh_wb_rsp_t wb_rsp_o,
  // Serial link to the device
  output logic sclk_o,
  output logic ss_n_o,
  output logic mosi_o,
  input wire logic miso_i,
  input wire logic irq_i
);
  localparam logic [5:0] NCSL_LAST = 6'(`RSH_NCSL_CYC - 1);
  localparam logic [5:0] NCSH_LAST = 6'(`RSH_NCSH_CYC - 1);
  localparam logic [5:0] SSH_LAST = 6'(`RSH_SSH_CYC - 1);
  localparam logic [6:0] LEN_MAX = 7'(FIFO_MAX);

  rsh_state_t state;
  rsh_cmd_t cmd, cmd_w;
  logic [1:0] pin_s;
  logic miso_s, irq_s, rise_p, fall_p;
  logic [5:0] tmr;
  logic [6:0] remain;
  logic [2:0] bitcnt;
  logic [7:0] shreg, txdata, rxdata;
  logic hdr, tx_full, rx_valid, err, wb_ack;
  logic [31:0] wb_dat;
  logic [7:0] wb_word;
  logic wb_hit, wr_ctrl, wr_tx, wr_stat, rd_rx;
  logic cmd_ok, can_start, start, is_read;
  logic byte_end, load_tx, load_rx, busy;

  // Pin inputs pass two flip-flops first
  rsh_sync #(.W(2)) u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i({miso_i, irq_i}),
    .q_o(pin_s)
  );
  assign miso_s = pin_s[1];
  assign irq_s = pin_s[0];

  // Serial clock generation
  rsh_sclk_div #(.HALF(HALF)) u_div (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .run_i(state == RSH_SHIFT),
    .sclk_o(sclk_o),
    .rise_o(rise_p),
    .fall_o(fall_p)
  );

  // Bus decode
  assign wb_hit = wb_req_i.cyc && wb_req_i.stb && !wb_ack;
  assign wb_word = {wb_req_i.adr[7:2], 2'b00};
  assign wr_ctrl = wb_hit && wb_req_i.we && wb_word == `RSH_OFS_CTRL
    && wb_req_i.sel[2:0] == 3'b111;
  assign wr_tx = wb_hit && wb_req_i.we && wb_word == `RSH_OFS_TXDATA
    && wb_req_i.sel[0];
  assign wr_stat = wb_hit && wb_req_i.we && wb_word == `RSH_OFS_STATUS
    && wb_req_i.sel[0];
  assign rd_rx = wb_hit && !wb_req_i.we && wb_word == `RSH_OFS_RXDATA;

  // Command word taken from the control write
  assign cmd_w.code = wb_req_i.dat[`RSH_CTRL_CODE_LSB +: 6];
  assign cmd_w.op = wb_req_i.dat[`RSH_CTRL_OP_LSB +: 2];
  assign cmd_w.len = wb_req_i.dat[`RSH_CTRL_LEN_LSB +: 7];
  assign cmd_w.keep = wb_req_i.dat[`RSH_CTRL_KEEP];
  assign cmd_w.long = wb_req_i.dat[`RSH_CTRL_LONG];

  // Legal operations only
  always_comb begin
    case (cmd_w.op)
      `RSH_OP_DCMD: cmd_ok = 1'b1;
      `RSH_OP_FIFO: cmd_ok = (cmd_w.code == `RSH_CODE_FIFO_LOAD
        || cmd_w.code == `RSH_CODE_FIFO_READ)
        && cmd_w.len != 7'h00 && cmd_w.len <= LEN_MAX;
      default: cmd_ok = cmd_w.len != 7'h00;
    endcase
  end

  assign can_start = state == RSH_IDLE || state == RSH_HOLD;
  assign start = wr_ctrl && can_start && cmd_ok;
  assign busy = state != RSH_IDLE && state != RSH_HOLD;
  assign is_read = cmd.op == `RSH_OP_REG_RD || (cmd.op == `RSH_OP_FIFO
    && cmd.code == `RSH_CODE_FIFO_READ);
  assign byte_end = state == RSH_SHIFT && fall_p && bitcnt == 3'd7;
  assign load_rx = state == RSH_GAP && remain != 7'h00 && is_read
    && !rx_valid;
  assign load_tx = state == RSH_GAP && remain != 7'h00 && !is_read
    && tx_full;

  // Transfer sequencer
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= RSH_IDLE;
      cmd <= '0;
      ss_n_o <= 1'b1;
      tmr <= 6'h00;
      remain <= 7'h00;
      hdr <= 1'b0;
      bitcnt <= 3'd0;
      shreg <= `RSH_RST_BYTE;
    end else begin
      case (state)
        RSH_IDLE: begin
          if (start) begin
            cmd <= cmd_w;
            ss_n_o <= 1'b0;
            tmr <= 6'h00;
            state <= RSH_LEAD;
          end
        end
        RSH_LEAD: begin
          tmr <= tmr + 6'h01;
          if (tmr == NCSL_LAST) begin
            shreg <= {cmd.op, cmd.code};
            hdr <= 1'b1;
            bitcnt <= 3'd0;
            remain <= (cmd.op == `RSH_OP_DCMD) ? 7'h00 : cmd.len;
            state <= RSH_SHIFT;
          end
        end
        RSH_HOLD: begin
          if (start) begin
            cmd <= cmd_w;
            shreg <= {cmd_w.op, cmd_w.code};
            hdr <= 1'b1;
            bitcnt <= 3'd0;
            remain <= (cmd_w.op == `RSH_OP_DCMD) ? 7'h00 : cmd_w.len;
            state <= RSH_SHIFT;
          end
        end
        RSH_SHIFT: begin
          if (fall_p) begin
            shreg <= {shreg[6:0], miso_s};
            bitcnt <= bitcnt + 3'd1;
            if (bitcnt == 3'd7) begin
              hdr <= 1'b0;
              if (!hdr) begin
                remain <= remain - 7'h01;
              end
              state <= RSH_GAP;
            end
          end
        end
        RSH_GAP: begin
          if (remain == 7'h00) begin
            tmr <= 6'h00;
            if (cmd.op == `RSH_OP_DCMD && cmd.keep && !cmd.long) begin
              state <= RSH_HOLD;
            end else begin
              state <= RSH_TAIL;
            end
          end else if (load_rx) begin
            shreg <= `RSH_RST_BYTE;
            state <= RSH_SHIFT;
          end else if (load_tx) begin
            shreg <= txdata;
            state <= RSH_SHIFT;
          end
        end
        RSH_TAIL: begin
          tmr <= tmr + 6'h01;
          if (tmr == NCSH_LAST) begin
            ss_n_o <= 1'b1;
            tmr <= 6'h00;
            state <= RSH_SSHI;
          end
        end
        RSH_SSHI: begin
          tmr <= tmr + 6'h01;
          if (tmr == SSH_LAST) begin
            if (cmd.op == `RSH_OP_DCMD && cmd.long) begin
              state <= RSH_WAITIRQ;
            end else begin
              state <= RSH_IDLE;
            end
          end
        end
        RSH_WAITIRQ: begin
          if (irq_s) begin
            state <= RSH_IDLE;
          end
        end
        default: begin
          state <= RSH_IDLE;
          ss_n_o <= 1'b1;
        end
      endcase
    end
  end

  // Output bit changes with the rising serial edge, and is cleared to zero while idle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mosi_o <= 1'b0;
    end else if (rise_p) begin
      mosi_o <= shreg[7];
    end else if (state == RSH_IDLE) begin
      mosi_o <= 1'b0;
    end
  end

  // Transmit holding byte; writes refused while full
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      txdata <= `RSH_RST_BYTE;
      tx_full <= 1'b0;
    end else if (load_tx) begin
      tx_full <= 1'b0;
    end else if (wr_tx && !tx_full) begin
      txdata <= wb_req_i.dat[7:0];
      tx_full <= 1'b1;
    end
  end

  // Receive holding byte; a new byte wins over the read clear
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rxdata <= `RSH_RST_BYTE;
      rx_valid <= 1'b0;
    end else if (byte_end && !hdr && is_read) begin
      rxdata <= {shreg[6:0], miso_s};
      rx_valid <= 1'b1;
    end else if (rd_rx) begin
      rx_valid <= 1'b0;
    end
  end

  // Sticky error for refused control writes; set wins over clear
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      err <= 1'b0;
    end else if (wr_ctrl && !(can_start && cmd_ok)) begin
      err <= 1'b1;
    end else if (wr_stat && wb_req_i.dat[`RSH_ST_ERR]) begin
      err <= 1'b0;
    end
  end

  // Bus answer one cycle after the request, dropped the next
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wb_ack <= 1'b0;
      wb_dat <= `RSH_RST_WORD;
    end else begin
      wb_ack <= wb_hit;
      if (wb_hit && !wb_req_i.we) begin
        case (wb_word)
          `RSH_OFS_CTRL: wb_dat <= {14'h0000, cmd.long, cmd.keep, 1'b0,
            cmd.len, cmd.op, cmd.code};
          `RSH_OFS_TXDATA: wb_dat <= {24'h000000, txdata};
          `RSH_OFS_RXDATA: wb_dat <= {24'h000000, rxdata};
          `RSH_OFS_STATUS: wb_dat <= {26'h0000000, state == RSH_HOLD,
            err, irq_s, rx_valid, tx_full, busy};
          default: wb_dat <= `RSH_RST_WORD;
        endcase
      end
    end
  end
  assign wb_rsp_o = '{ack: wb_ack, dat: wb_dat};

  // Checks on the link behaviour
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  property p_idle_select_high;
    state == RSH_IDLE || state == RSH_WAITIRQ |-> ss_n_o;
  endproperty
  a_idle_select_high: assert property (p_idle_select_high)
    else $error("select low while idle");
  property p_lead_gap;
    $fell(ss_n_o) |-> !sclk_o [*3];
  endproperty
  a_lead_gap: assert property (p_lead_gap)
    else $error("clock too soon after select fell");
  property p_eight_bits;
    byte_end |=> state == RSH_GAP && bitcnt == 3'd0;
  endproperty
  a_eight_bits: assert property (p_eight_bits)
    else $error("byte did not end after eight bits");
  property p_header_msb;
    rise_p && hdr && bitcnt == 3'd0 |=> mosi_o == cmd.op[1];
  endproperty
  a_header_msb: assert property (p_header_msb)
    else $error("header not sent msb first");
  property p_mosi_on_rise;
    $changed(mosi_o) && state != RSH_IDLE |-> $past(rise_p);
  endproperty
  a_mosi_on_rise: assert property (p_mosi_on_rise)
    else $error("data out changed off the rising edge");
  // Every fifo data byte shifted lies inside the granted length
  property p_fifo_len;
    byte_end && !hdr && cmd.op == `RSH_OP_FIFO |-> remain != 7'h00
      && remain <= LEN_MAX;
  endproperty
  a_fifo_len: assert property (p_fifo_len)
    else $error("fifo transfer length out of range");
  property p_read_zero_out;
    rise_p && !hdr && is_read |=> !mosi_o;
  endproperty
  a_read_zero_out: assert property (p_read_zero_out)
    else $error("nonzero filler during read");
  property p_dcmd_single;
    state == RSH_GAP && cmd.op == `RSH_OP_DCMD |-> remain == 7'h00;
  endproperty
  a_dcmd_single: assert property (p_dcmd_single)
    else $error("direct command longer than one byte");
  property p_long_quiet;
    state == RSH_WAITIRQ |-> ss_n_o && !sclk_o && !start;
  endproperty
  a_long_quiet: assert property (p_long_quiet)
    else $error("activity during long command");
  property p_chain_hold;
    state == RSH_HOLD |-> !ss_n_o && $past(cmd.op) == `RSH_OP_DCMD;
  endproperty
  a_chain_hold: assert property (p_chain_hold)
    else $error("chain hold without direct command");
  property p_tail_release;
    $rose(ss_n_o) |-> !$past(sclk_o, 30) ##1 ss_n_o [*8];
  endproperty
  a_tail_release: assert property (p_tail_release)
    else $error("select timing around release wrong");

  c_fifo_read: cover property (byte_end && !hdr && is_read
    && cmd.op == `RSH_OP_FIFO);
  c_reg_burst: cover property (load_tx && cmd.op == `RSH_OP_REG_WR
    && remain == 7'd1 && cmd.len == 7'd2);
  c_chain: cover property (state == RSH_HOLD && start);
  c_long_done: cover property (state == RSH_WAITIRQ && irq_s);
endmodule // rsh_host

// *** dv/rsh_dev_model.sv ***
// Behavioural reader device on the far side of the serial link
`timescale 1ns/1ns
module rsh_dev_model #(
  parameter logic [7:0] RO_VAL = 8'h3c,
  parameter logic [5:0] LONG_CODE = 6'h10,
  parameter int LONG_CYC = 200
) (
  // Clock for the long command timer
  input wire logic clk_i,
  // Serial link
  input wire logic sclk_i,
  input wire logic ss_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic irq_o
);
  logic [7:0] regs [0:55];
  logic [7:0] fifo [$];
  logic [6:0] sr;
  logic [2:0] bcnt;
  logic [1:0] op;
  logic [5:0] adr;
  logic [7:0] obyte;
  logic hdr, drive, last;
  int n_dcmd, irq_cnt;

  // Map: rw below 0x38, four read-only, rest absent
  function automatic logic [7:0] rd_reg(input logic [5:0] a);
    if (a < 6'h38) return regs[a];
    return (a < 6'h3c) ? RO_VAL : 8'h00;
  endfunction

  // Decode of a completed byte
  task automatic take(input logic [7:0] bt);
    logic ok;
    ok = regs[2][7];
    if (hdr) begin
      {op, adr} = bt;
      hdr = (op == 2'b11);
      if (op == 2'b11) n_dcmd++;
      if (op == 2'b11 && adr == LONG_CODE) irq_cnt = LONG_CYC;
      if (op == 2'b01) obyte = rd_reg(adr);
      if (op == 2'b10) obyte = (ok && fifo.size() > 0) ? fifo[0] : 8'h00;
    end else if (op == 2'b00) begin
      if (adr < 6'h38) regs[adr] = bt;
      adr++;
    end else if (op == 2'b01) begin
      if (adr == 6'h17) irq_o = 1'b0;
      adr++;
      obyte = rd_reg(adr);
    end else if (op == 2'b10 && adr == 6'h00 && ok && fifo.size() < 96) begin
      fifo.push_back(bt);
    end else if (op == 2'b10 && adr == 6'h3f && ok) begin
      if (fifo.size() > 0) void'(fifo.pop_front());
      obyte = (fifo.size() > 0) ? fifo[0] : 8'h00;
    end
  endtask

  initial begin
    foreach (regs[i]) regs[i] = 8'h00;
    {sr, bcnt, op, adr, obyte} = '0;
    hdr = 1'b1;
    drive = 1'b0;
    last = 1'b0;
    irq_o = 1'b0;
    n_dcmd = 0;
    irq_cnt = 0;
  end

  // Port held in reset while select is high, partial byte lost
  always @(posedge ss_n_i) begin
    bcnt = 3'h0;
    hdr = 1'b1;
    drive = 1'b0;
  end

  // Input taken on falling serial clock, msb first
  always @(negedge sclk_i) if (!ss_n_i) begin
    if (bcnt == 3'h7) take({sr, mosi_i});
    else sr = {sr[5:0], mosi_i};
    bcnt++;
  end

  // Read data launched on rising serial clock
  always @(posedge sclk_i) if (!ss_n_i && !hdr &&
      (op == 2'b01 || (op == 2'b10 && adr == 6'h3f))) begin
    drive = 1'b1;
    last = obyte[3'h7 - bcnt];
  end

  // Undriven line shows the opposite of the last bit
  assign miso_o = drive ? last : ~last;

  // Long command raises the interrupt when done
  always @(posedge clk_i) if (irq_cnt > 0) begin
    irq_cnt--;
    if (irq_cnt == 0) irq_o = 1'b1;
  end
endmodule // rsh_dev_model

// *** dv/tb.sv ***
// Self-checking bench for the serial host controller
`timescale 1ns/1ns
`include "rsh_regs.svh"
module tb;
  import rsh_pkg::*;
  localparam logic [7:0] RO_VAL = 8'h3c;
  localparam logic [5:0] LONG_CODE = 6'h10;
  typedef struct {
    logic [5:0] adr;
    int len;
    logic [31:0] wd;
    logic [31:0] exp;
  } rsh_row_t;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  rsh_wb_req_t req = '0;
  rsh_wb_rsp_t rsp;
  logic sclk, ss_n, mosi, miso, irq;
  int n_fail = 0;
  int checked = 0;
  logic [31:0] q;
  logic [7:0] b [$];
  rsh_row_t rows [4] = '{'{6'h05, 1, 32'ha5, 32'ha5},
    '{6'h10, 3, 32'h123456, 32'h123456},
    '{6'h3b, 2, 32'h5a6b, {16'h0, RO_VAL, 8'h00}},
    '{6'h3f, 1, 32'h77, 32'h0}};
  logic [31:0] bad [3] = '{32'h0005, 32'h0195, 32'h6180};

  // System clock
  always #5 clk_i = ~clk_i;

  rsh_host #(.HALF(4)) dut (.clk_i(clk_i), .resetn_i(resetn_i),
    .wb_req_i(req), .wb_rsp_o(rsp), .sclk_o(sclk), .ss_n_o(ss_n),
    .mosi_o(mosi), .miso_i(miso), .irq_i(irq));
  rsh_dev_model #(.RO_VAL(RO_VAL), .LONG_CODE(LONG_CODE), .LONG_CYC(200))
    u_dev (.clk_i(clk_i), .sclk_i(sclk), .ss_n_i(ss_n), .mosi_i(mosi),
    .miso_o(miso), .irq_o(irq));

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  // One classic Wishbone cycle, result in q
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.ack !== 1'b1 && n < 50);
    q = rsp.dat;
    if (n >= 50) chk("ack", 32'h1, 32'h0);
    req <= '0;
    @(posedge clk_i);
  endtask

  // Poll one status bit under a bound
  task automatic wait_st(input int pos, input logic v);
    int n;
    n = 0;
    do begin
      wb(1'b0, `RSH_OFS_STATUS, 32'h0);
      n++;
    end while (q[pos] !== v && n < 3000);
    chk("status wait", 32'(v), 32'(q[pos]));
  endtask

  task automatic ctrl(input logic [1:0] op, input logic [5:0] c,
                      input logic [6:0] len, input logic keep, lng);
    wb(1'b1, `RSH_OFS_CTRL, {14'h0, lng, keep, 1'b0, len, op, c});
  endtask

  // Send the bytes of b after a header
  task automatic spi_wr(input logic [1:0] op, input logic [5:0] c);
    wb(1'b1, `RSH_OFS_TXDATA, {24'h0, b[0]});
    ctrl(op, c, 7'(b.size()), 1'b0, 1'b0);
    for (int i = 1; i < b.size(); i++) begin
      wait_st(`RSH_ST_TXFULL, 1'b0);
      wb(1'b1, `RSH_OFS_TXDATA, {24'h0, b[i]});
    end
    wait_st(`RSH_ST_BUSY, 1'b0);
  endtask

  // Fetch n bytes into b after a header
  task automatic spi_rd(input logic [1:0] op, input logic [5:0] c,
                        input int n);
    b.delete();
    ctrl(op, c, 7'(n), 1'b0, 1'b0);
    repeat (n) begin
      wait_st(`RSH_ST_RXVALID, 1'b1);
      wb(1'b0, `RSH_OFS_RXDATA, 32'h0);
      b.push_back(q[7:0]);
    end
    wait_st(`RSH_ST_BUSY, 1'b0);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    #400000;
    n_fail++;
    finish_test();
  end

  initial begin
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    // Idle levels, reset values, unmapped place
    chk("ss_n idle", 32'h1, 32'(ss_n));
    chk("sclk idle", 32'h0, 32'(sclk));
    wb(1'b0, `RSH_OFS_STATUS, 32'h0);
    chk("status reset", 32'h0, q);
    wb(1'b0, `RSH_OFS_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, q);
    wb(1'b1, 8'h20, 32'hffff_ffff);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("test reset done");
    // Register write then read back, per row
    foreach (rows[r]) begin
      b.delete();
      for (int i = rows[r].len - 1; i >= 0; i--)
        b.push_back(rows[r].wd[8*i +: 8]);
      spi_wr(2'b00, rows[r].adr);
      spi_rd(2'b01, rows[r].adr, rows[r].len);
      q = 32'h0;
      foreach (b[i]) q = {q[23:0], b[i]};
      chk("reg rows", rows[r].exp, q);
    end
    $display("test register rows done");
    // Full transmit holding byte refuses a second one
    wb(1'b1, `RSH_OFS_TXDATA, 32'h11);
    wb(1'b1, `RSH_OFS_TXDATA, 32'h22);
    wb(1'b0, `RSH_OFS_TXDATA, 32'h0);
    chk("txdata held", 32'h11, {24'h0, q[7:0]});
    ctrl(2'b00, 6'h06, 7'h1, 1'b0, 1'b0);
    wait_st(`RSH_ST_BUSY, 1'b0);
    chk("reg 06", 32'h11, {24'h0, u_dev.regs[6]});
    $display("test tx full done");
    // FIFO ignored until enabled, then load and read
    b = '{8'hc1, 8'hc2, 8'hc3};
    spi_wr(2'b10, 6'h00);
    chk("fifo off", 32'h0, 32'(u_dev.fifo.size()));
    b = '{8'h80};
    spi_wr(2'b00, 6'h02);
    b = '{8'hc1, 8'hc2, 8'hc3};
    spi_wr(2'b10, 6'h00);
    spi_rd(2'b10, 6'h3f, 3);
    chk("fifo data", 32'hc1c2c3, {8'h00, b[0], b[1], b[2]});
    $display("test fifo done");
    // Illegal orders refused with error, no traffic
    foreach (bad[i]) begin
      wb(1'b1, `RSH_OFS_CTRL, bad[i]);
      wb(1'b0, `RSH_OFS_STATUS, 32'h0);
      chk("err set", 32'h10, q & 32'h11);
      chk("ss_n refused", 32'h1, 32'(ss_n));
      wb(1'b1, `RSH_OFS_STATUS, 32'h10);
    end
    wb(1'b0, `RSH_OFS_STATUS, 32'h0);
    chk("err clear", 32'h0, q & 32'h10);
    $display("test refusals done");
    // Long direct command: busy until interrupt
    ctrl(2'b11, LONG_CODE, 7'h0, 1'b0, 1'b1);
    wb(1'b1, `RSH_OFS_CTRL, 32'h00c5);
    wb(1'b0, `RSH_OFS_STATUS, 32'h0);
    chk("busy long", 32'h11, q & 32'h19);
    wait_st(`RSH_ST_BUSY, 1'b0);
    chk("irq seen", 32'h1, 32'(q[`RSH_ST_IRQ]));
    chk("dcmd count", 32'h1, 32'(u_dev.n_dcmd));
    wb(1'b1, `RSH_OFS_STATUS, 32'h10);
    spi_rd(2'b01, 6'h17, 1);
    wait_st(`RSH_ST_IRQ, 1'b0);
    $display("test long command done");
    // Immediate command chained to a write under one select
    ctrl(2'b11, 6'h05, 7'h0, 1'b1, 1'b0);
    wait_st(`RSH_ST_HOLD, 1'b1);
    chk("ss held", 32'h0, 32'(ss_n));
    b = '{8'h99};
    spi_wr(2'b00, 6'h20);
    chk("chained write", 32'h99, {24'h0, u_dev.regs[32]});
    chk("dcmd chain", 32'h2, 32'(u_dev.n_dcmd));
    chk("ss released", 32'h1, 32'(ss_n));
    $display("test chain done");
    // Reset in mid-run while select is held low
    ctrl(2'b11, 6'h05, 7'h0, 1'b1, 1'b0);
    wait_st(`RSH_ST_HOLD, 1'b1);
    resetn_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    chk("ss_n after reset", 32'h1, 32'(ss_n));
    chk("sclk after reset", 32'h0, 32'(sclk));
    wb(1'b0, `RSH_OFS_STATUS, 32'h0);
    chk("status after reset", 32'h0, q);
    spi_rd(2'b01, 6'h20, 1);
    chk("read after reset", 32'h99, {24'h0, b[0]});
    $display("test mid-run reset done");
    finish_test();
  end
endmodule // tb
